// File: rtl/lec_pkg.sv
// Constants, field layout and encodings of the lookup engine control block.
// Assumes a 32-bit APB slave where each register index maps to one aligned word.
package lec_pkg;

  localparam int unsigned LEC_ADDR_W = 12;
  // Register indices and byte addresses (byte address is four times the index).
  localparam logic [11:0] LEC_CTRL2_IDX = 12'h0312;
  localparam logic [11:0] LEC_FCMD_IDX = 12'h03f0;
  localparam logic [11:0] LEC_CTRL2_ADDR = {LEC_CTRL2_IDX[9:0], 2'b00};
  localparam logic [11:0] LEC_FCMD_ADDR = {LEC_FCMD_IDX[9:0], 2'b00};

  // Field positions of lookup_engine_control_two.
  localparam int unsigned LEC_RSVD_BIT = 7;
  localparam int unsigned LEC_TRAP_BIT = 6;
  localparam int unsigned LEC_DYN_FILT_BIT = 5;
  localparam int unsigned LEC_STAT_FILT_BIT = 4;
  localparam int unsigned LEC_SCOPE_LSB = 2;
  localparam int unsigned LEC_PSEL_LSB = 0;
  localparam logic [7:0] LEC_CTRL2_RESET = 8'h00;

  // Field positions of the flush command register.
  localparam int unsigned LEC_FULL_BIT = 0;
  localparam int unsigned LEC_STP_BIT = 1;
  localparam int unsigned LEC_BUSY_BIT = 2;

  typedef enum logic [1:0] {
    LEC_SCOPE_NONE = 2'b00,
    LEC_SCOPE_DYN = 2'b01,
    LEC_SCOPE_STAT = 2'b10,
    LEC_SCOPE_BOTH = 2'b11
  } lec_scope_e;

  typedef enum logic [1:0] {
    LEC_PRIO_DA = 2'b00,
    LEC_PRIO_SA = 2'b01,
    LEC_PRIO_HIGH = 2'b10,
    LEC_PRIO_LOW = 2'b11
  } lec_prio_e;

  typedef enum logic [1:0] {
    LEC_F_IDLE = 2'b00,
    LEC_F_READ = 2'b01,
    LEC_F_WAIT = 2'b10,
    LEC_F_DECIDE = 2'b11
  } lec_fstate_e;

endpackage

// File: rtl/lec_fwd.sv
// Forwarding result stage: port map masking, reserved multicast trap, priority pick.
// Assumes lookup results arrive synchronous to core_clk_in, one per valid cycle.
`timescale 1ns/10ps
`default_nettype none
module lec_fwd
  import lec_pkg::*;
#(
  parameter int unsigned PORTS = 3,
  parameter int unsigned PRIO_W = 3
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] cfg_in,
  input wire logic lookup_valid_in,
  input wire logic hit_in,
  input wire logic hit_static_in,
  input wire logic [PORTS-1:0] entry_map_in,
  input wire logic [PORTS-1:0] vlan_map_in,
  input wire logic [PORTS-1:0] miss_map_in,
  input wire logic [PORTS-1:0] host_map_in,
  input wire logic reserved_mc_in,
  input wire logic double_tag_in,
  input wire logic [PRIO_W-1:0] da_prio_in,
  input wire logic [PRIO_W-1:0] sa_prio_in,
  output logic fwd_valid_out,
  output logic [PORTS-1:0] fwd_map_out,
  output logic [PRIO_W-1:0] mac_lookup_priority_out
);

  typedef struct packed {
    logic valid;
    logic [PORTS-1:0] map;
    logic [PRIO_W-1:0] prio;
  } lec_fwd_s;

  lec_fwd_s s_q;
  lec_fwd_s s_d;
  lec_prio_e sel;
  logic filt;

  always_comb begin
    s_d = s_q;
    sel = lec_prio_e'(cfg_in[LEC_PSEL_LSB +: 2]);
    filt = hit_static_in ? cfg_in[LEC_STAT_FILT_BIT] : cfg_in[LEC_DYN_FILT_BIT];
    s_d.valid = lookup_valid_in;
    if (lookup_valid_in) begin
      if (reserved_mc_in && double_tag_in && cfg_in[LEC_TRAP_BIT]) begin
        s_d.map = host_map_in;
      end else if (hit_in) begin
        s_d.map = filt ? (entry_map_in & vlan_map_in) : entry_map_in;
      end else begin
        s_d.map = miss_map_in;
      end
      unique case (sel)
        LEC_PRIO_DA: s_d.prio = da_prio_in;
        LEC_PRIO_SA: s_d.prio = sa_prio_in;
        LEC_PRIO_HIGH: s_d.prio = (da_prio_in > sa_prio_in) ? da_prio_in : sa_prio_in;
        LEC_PRIO_LOW: s_d.prio = (da_prio_in < sa_prio_in) ? da_prio_in : sa_prio_in;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fwd_valid_out = s_q.valid;
  assign fwd_map_out = s_q.map;
  assign mac_lookup_priority_out = s_q.prio;

  host_trap_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    lookup_valid_in && reserved_mc_in && double_tag_in && cfg_in[LEC_TRAP_BIT]
    |=> fwd_map_out == $past(host_map_in))
    else $error("Reserved multicast not trapped to host port.");
  dyn_filter_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    lookup_valid_in && !reserved_mc_in && hit_in && !hit_static_in
    |=> fwd_map_out == ($past(entry_map_in) &
        ($past(cfg_in[LEC_DYN_FILT_BIT]) ? $past(vlan_map_in) : {PORTS{1'b1}})))
    else $error("Dynamic hit port map wrong.");
  stat_filter_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    lookup_valid_in && !reserved_mc_in && hit_in && hit_static_in
    |=> fwd_map_out == ($past(entry_map_in) &
        ($past(cfg_in[LEC_STAT_FILT_BIT]) ? $past(vlan_map_in) : {PORTS{1'b1}})))
    else $error("Static hit port map wrong.");
  miss_pass_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    lookup_valid_in && !reserved_mc_in && !hit_in |=> fwd_map_out == $past(miss_map_in))
    else $error("Miss port map altered.");
  prio_src_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    lookup_valid_in && !cfg_in[1] |=> fwd_valid_out && mac_lookup_priority_out ==
      ($past(cfg_in[0]) ? $past(sa_prio_in) : $past(da_prio_in)))
    else $error("Priority source wrong.");
  prio_cmp_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    lookup_valid_in && cfg_in[1] |=> (mac_lookup_priority_out == $past(da_prio_in) ||
      mac_lookup_priority_out == $past(sa_prio_in)) && ($past(cfg_in[0]) ?
      (mac_lookup_priority_out <= $past(sa_prio_in) &&
      mac_lookup_priority_out <= $past(da_prio_in)) :
      (mac_lookup_priority_out >= $past(sa_prio_in) &&
      mac_lookup_priority_out >= $past(da_prio_in))))
    else $error("Priority compare wrong.");

endmodule
`default_nettype wire

// File: rtl/lec_top.sv
// Lookup engine control two: APB register slave, table flush sequencer, forwarding stage.
// Assumes an APB master on core_clk_in and a lookup table that answers a read one cycle
// after table_rd_out and removes an entry on table_erase_out.
`timescale 1ns/10ps
`default_nettype none
module lec_top
  import lec_pkg::*;
#(
  parameter int unsigned PORTS = 3,
  parameter int unsigned PRIO_W = 3,
  parameter int unsigned FLUSH_ENTRIES = 1024,
  parameter int unsigned IDX_W = $clog2(FLUSH_ENTRIES)
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic table_rd_out,
  output logic [IDX_W-1:0] table_idx_out,
  input wire logic entry_valid_in,
  input wire logic entry_static_in,
  input wire logic entry_stp_match_in,
  output logic table_erase_out,
  output logic flush_busy_out,
  input wire logic lookup_valid_in,
  input wire logic hit_in,
  input wire logic hit_static_in,
  input wire logic [PORTS-1:0] entry_map_in,
  input wire logic [PORTS-1:0] vlan_map_in,
  input wire logic [PORTS-1:0] miss_map_in,
  input wire logic [PORTS-1:0] host_map_in,
  input wire logic reserved_mc_in,
  input wire logic double_tag_in,
  input wire logic [PRIO_W-1:0] da_prio_in,
  input wire logic [PRIO_W-1:0] sa_prio_in,
  output logic fwd_valid_out,
  output logic [PORTS-1:0] fwd_map_out,
  output logic [PRIO_W-1:0] mac_lookup_priority_out
);

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FLUSH_ENTRIES - 1);

  typedef struct packed {
    logic [7:0] ctrl2;
    logic full_trig;
    logic stp_trig;
    lec_fstate_e st;
    logic [IDX_W-1:0] idx;
    lec_scope_e scope;
    logic kind_full;
    logic rd;
    logic erase;
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lec_top_s;

  lec_top_s s_q;
  lec_top_s s_d;
  logic hit_c2;
  logic hit_fc;
  logic acc;
  logic wr_lo;
  logic kill;

  assign hit_c2 = (paddr == LEC_CTRL2_ADDR);
  assign hit_fc = (paddr == LEC_FCMD_ADDR);
  assign acc = psel && penable && s_q.pready;
  assign wr_lo = acc && pwrite && pstrb[0];

  // Erase decision for the entry returned by the table in DECIDE.
  always_comb begin
    kill = entry_valid_in && (s_q.kind_full || entry_stp_match_in);
    kill = kill && (entry_static_in ? s_q.scope[1] : s_q.scope[0]);
  end

  always_comb begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.erase = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !(hit_c2 || hit_fc);
      if (hit_c2) begin
        s_d.prdata = {24'h00_0000, s_q.ctrl2};
      end else if (hit_fc) begin
        s_d.prdata = {29'h0000_0000, s_q.busy, s_q.stp_trig, s_q.full_trig};
      end else begin
        s_d.prdata = 32'h0000_0000;
      end
    end
    unique case (s_q.st)
      LEC_F_IDLE: begin
        if (s_q.full_trig || s_q.stp_trig) begin
          // The scope is latched so a mid-flush rewrite cannot change what gets removed.
          s_d.scope = lec_scope_e'(s_q.ctrl2[LEC_SCOPE_LSB +: 2]);
          s_d.kind_full = s_q.full_trig;
          // The index starts one below entry zero and each READ steps it, so it stays
          // on the entry under work through the read, the answer and the erase pulse.
          s_d.idx = '1;
          if (lec_scope_e'(s_q.ctrl2[LEC_SCOPE_LSB +: 2]) == LEC_SCOPE_NONE) begin
            s_d.full_trig = 1'b0;
            s_d.stp_trig = 1'b0;
          end else begin
            s_d.busy = 1'b1;
            s_d.st = LEC_F_READ;
          end
        end
      end
      LEC_F_READ: begin
        s_d.rd = 1'b1;
        s_d.idx = s_q.idx + 1'b1;
        s_d.st = LEC_F_WAIT;
      end
      LEC_F_WAIT: begin
        s_d.st = LEC_F_DECIDE;
      end
      LEC_F_DECIDE: begin
        s_d.erase = kill;
        if (s_q.idx == LAST_IDX) begin
          s_d.full_trig = 1'b0;
          s_d.stp_trig = 1'b0;
          s_d.ctrl2[LEC_SCOPE_LSB +: 2] = LEC_SCOPE_NONE;
          s_d.busy = 1'b0;
          s_d.st = LEC_F_IDLE;
        end else begin
          s_d.st = LEC_F_READ;
        end
      end
    endcase
    // Software writes come last so a write in the finishing cycle wins.
    if (wr_lo && hit_c2) begin
      s_d.ctrl2 = pwdata[7:0];
    end
    if (wr_lo && hit_fc && pwdata[LEC_FULL_BIT]) begin
      s_d.full_trig = 1'b1;
    end
    if (wr_lo && hit_fc && pwdata[LEC_STP_BIT]) begin
      s_d.stp_trig = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.ctrl2 <= LEC_CTRL2_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign table_rd_out = s_q.rd;
  assign table_idx_out = s_q.idx;
  assign table_erase_out = s_q.erase;
  assign flush_busy_out = s_q.busy;

  lec_fwd #(
    .PORTS(PORTS),
    .PRIO_W(PRIO_W)
  ) u_fwd (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .cfg_in(s_q.ctrl2),
    .lookup_valid_in(lookup_valid_in),
    .hit_in(hit_in),
    .hit_static_in(hit_static_in),
    .entry_map_in(entry_map_in),
    .vlan_map_in(vlan_map_in),
    .miss_map_in(miss_map_in),
    .host_map_in(host_map_in),
    .reserved_mc_in(reserved_mc_in),
    .double_tag_in(double_tag_in),
    .da_prio_in(da_prio_in),
    .sa_prio_in(sa_prio_in),
    .fwd_valid_out(fwd_valid_out),
    .fwd_map_out(fwd_map_out),
    .mac_lookup_priority_out(mac_lookup_priority_out)
  );

  reset_value_a: assert property (@(posedge core_clk_in)
    $past(!nrst_in) && nrst_in |-> s_q.ctrl2 == 8'h00 && !table_erase_out)
    else $error("Control register not cleared by reset.");
  erase_scope_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    table_erase_out |-> $past(entry_valid_in) &&
      ($past(entry_static_in) ? s_q.scope[1] : s_q.scope[0]))
    else $error("Erase outside selected scope.");
  stp_match_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    table_erase_out && !s_q.kind_full |-> $past(entry_stp_match_in))
    else $error("Spanning-tree flush erased unmatched entry.");
  scope_none_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    s_q.st == LEC_F_IDLE && s_q.full_trig && s_q.ctrl2[3:2] == 2'b00 && !wr_lo
    |=> (!s_q.full_trig && s_q.st == LEC_F_IDLE) [*2])
    else $error("Scope zero still started a flush.");
  read_erase_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    table_rd_out |=> ##1 s_q.st == LEC_F_READ || s_q.st == LEC_F_IDLE)
    else $error("Flush step timing wrong.");
  flush_done_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    s_q.st == LEC_F_DECIDE && s_q.idx == LAST_IDX && !wr_lo
    |=> !flush_busy_out && !s_q.full_trig && s_q.ctrl2[3:2] == 2'b00)
    else $error("Flush did not finish cleanly.");
  rsvd_rw_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_lo && hit_c2 |=> s_q.ctrl2[LEC_RSVD_BIT] == $past(pwdata[7]))
    else $error("Reserved bit not writable.");

endmodule
`default_nettype wire

// File: tb/tb_lec_top.sv
// Self-checking testbench for lec_top: register access, forwarding, priority pick and flush.
// Assumes a four-entry lookup table, which the bench answers one cycle after each table read.
`timescale 1ns/10ps
`default_nettype none
module tb_lec_top;
  import lec_pkg::*;
  localparam int unsigned NE = 4;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, table_rd_out, table_erase_out, flush_busy_out, fwd_valid_out;
  logic [31:0] prdata;
  logic [1:0] table_idx_out;
  logic entry_valid_in = 1'b0;
  logic entry_static_in = 1'b0;
  logic entry_stp_match_in = 1'b0;
  logic lookup_valid_in = 1'b0;
  logic hit_in = 1'b0;
  logic hit_static_in = 1'b0;
  logic reserved_mc_in = 1'b0;
  logic double_tag_in = 1'b0;
  logic [2:0] entry_map_in = 3'h6;
  logic [2:0] vlan_map_in = 3'h3;
  logic [2:0] miss_map_in = 3'h5;
  logic [2:0] host_map_in = 3'h1;
  logic [2:0] da_prio_in = 3'h0;
  logic [2:0] sa_prio_in = 3'h0;
  logic [2:0] fwd_map_out, mac_lookup_priority_out;
  logic [3:0] emask = 4'h0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  lec_top #(.PORTS(3), .PRIO_W(3), .FLUSH_ENTRIES(NE)) dut (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .table_rd_out(table_rd_out),
    .table_idx_out(table_idx_out), .entry_valid_in(entry_valid_in),
    .entry_static_in(entry_static_in), .entry_stp_match_in(entry_stp_match_in),
    .table_erase_out(table_erase_out), .flush_busy_out(flush_busy_out),
    .lookup_valid_in(lookup_valid_in), .hit_in(hit_in), .hit_static_in(hit_static_in),
    .entry_map_in(entry_map_in), .vlan_map_in(vlan_map_in), .miss_map_in(miss_map_in),
    .host_map_in(host_map_in), .reserved_mc_in(reserved_mc_in),
    .double_tag_in(double_tag_in), .da_prio_in(da_prio_in), .sa_prio_in(sa_prio_in),
    .fwd_valid_out(fwd_valid_out), .fwd_map_out(fwd_map_out),
    .mac_lookup_priority_out(mac_lookup_priority_out)
  );

  always #4 core_clk_in = ~core_clk_in;

  // Table model: odd entries are static, entries 2 and 3 match the spanning tree.
  // Outside an answer cycle valid is low and the static and match lines toggle so that a late sample is not rewarded.
  always @(posedge core_clk_in) begin
    if (table_rd_out === 1'b1) begin
      entry_valid_in <= 1'b1;
      entry_static_in <= table_idx_out[0];
      entry_stp_match_in <= table_idx_out[1];
    end else begin
      entry_valid_in <= 1'b0;
      entry_static_in <= ~entry_static_in;
      entry_stp_match_in <= ~entry_stp_match_in;
    end
    if (table_erase_out === 1'b1) begin
      emask[table_idx_out] <= 1'b1;
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, exp, rd);
    chk("pslverr", 32'h0000_0000, {31'h0, err});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic reg_access();
    logic [31:0] rd;
    logic err;
    reg_chk(LEC_CTRL2_ADDR, 32'h0000_0000, "ctrl2 reset");
    wr(LEC_CTRL2_ADDR, 32'h0000_00f3);
    reg_chk(LEC_CTRL2_ADDR, 32'h0000_00f3, "ctrl2 rw");
    wr(LEC_CTRL2_ADDR, 32'h0000_0000);
    reg_chk(LEC_CTRL2_ADDR, 32'h0000_0000, "ctrl2 clear");
    pstrb <= 4'he;
    wr(LEC_CTRL2_ADDR, 32'h0000_00ff);
    pstrb <= 4'hf;
    reg_chk(LEC_CTRL2_ADDR, 32'h0000_0000, "ctrl2 strobe off");
    apb(1'b0, 12'h004, 32'h0000_0000, rd, err);
    chk("unmapped pslverr", 32'h0000_0001, {31'h0, err});
    chk("unmapped prdata", 32'h0000_0000, rd);
  endtask

  // One lookup result under a given control value; the answer is looked at one cycle later.
  task automatic fwd_case(input logic [7:0] cfg, input logic h, input logic s, input logic r,
                          input logic t, input logic [2:0] exp);
    wr(LEC_CTRL2_ADDR, {24'h0, cfg});
    @(posedge core_clk_in);
    lookup_valid_in <= 1'b1;
    hit_in <= h;
    hit_static_in <= s;
    reserved_mc_in <= r;
    double_tag_in <= t;
    @(posedge core_clk_in);
    lookup_valid_in <= 1'b0;
    @(posedge core_clk_in);
    chk("fwd_valid", 32'h0000_0001, {31'h0, fwd_valid_out});
    chk("fwd_map", {29'h0, exp}, {29'h0, fwd_map_out});
  endtask

  task automatic prio_case(input logic [1:0] sel, input logic [2:0] da, input logic [2:0] sa,
                           input logic [2:0] exp);
    da_prio_in <= da;
    sa_prio_in <= sa;
    fwd_case({6'h0, sel}, 1'b1, 1'b0, 1'b0, 1'b0, 3'h6);
    chk("mac_lookup_priority", {29'h0, exp}, {29'h0, mac_lookup_priority_out});
  endtask

  // Runs one flush and compares the erased entries with those the scope and kind allow.
  task automatic flush_case(input logic [1:0] scope, input logic [1:0] trig);
    logic [3:0] exp;
    int n;
    exp = 4'h0;
    for (int i = 0; i < NE; i++) begin
      exp[i] = (i[0] ? scope[1] : scope[0]) && (trig[0] || i[1]);
    end
    emask = 4'h0;
    wr(LEC_CTRL2_ADDR, {28'h0, scope, 2'b00});
    wr(LEC_FCMD_ADDR, {30'h0, trig});
    // Busy rises one cycle after the trigger lands, so it is looked at two edges later.
    repeat (2) @(posedge core_clk_in);
    chk("flush busy", {31'h0, scope != 2'b00}, {31'h0, flush_busy_out});
    n = 0;
    while (flush_busy_out === 1'b1 && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 200) begin
      n_mismatch++;
      give_verdict();
    end
    repeat (2) @(posedge core_clk_in);
    chk("erased entries", {28'h0, exp}, {28'h0, emask});
    reg_chk(LEC_FCMD_ADDR, 32'h0000_0000, "flush triggers");
    reg_chk(LEC_CTRL2_ADDR, 32'h0000_0000, "scope after flush");
  endtask

  initial begin
    repeat (20) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    reg_access();
    fwd_case(8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 3'h6);
    fwd_case(8'h20, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2);
    fwd_case(8'h20, 1'b1, 1'b1, 1'b0, 1'b0, 3'h6);
    fwd_case(8'h10, 1'b1, 1'b1, 1'b0, 1'b0, 3'h2);
    fwd_case(8'h10, 1'b1, 1'b0, 1'b0, 1'b0, 3'h6);
    fwd_case(8'h30, 1'b0, 1'b0, 1'b0, 1'b0, 3'h5);
    fwd_case(8'h40, 1'b1, 1'b0, 1'b1, 1'b1, 3'h1);
    fwd_case(8'h40, 1'b1, 1'b0, 1'b1, 1'b0, 3'h6);
    fwd_case(8'h30, 1'b1, 1'b0, 1'b1, 1'b1, 3'h2);
    fwd_case(8'hc0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1);
    prio_case(2'b00, 3'h5, 3'h2, 3'h5);
    prio_case(2'b01, 3'h5, 3'h2, 3'h2);
    prio_case(2'b10, 3'h2, 3'h6, 3'h6);
    prio_case(2'b10, 3'h5, 3'h2, 3'h5);
    prio_case(2'b11, 3'h2, 3'h6, 3'h2);
    prio_case(2'b11, 3'h5, 3'h2, 3'h2);
    flush_case(2'b01, 2'b01);
    flush_case(2'b10, 2'b01);
    flush_case(2'b11, 2'b01);
    flush_case(2'b11, 2'b10);
    flush_case(2'b01, 2'b10);
    flush_case(2'b00, 2'b01);
    give_verdict();
  end
endmodule
`default_nettype wire
